//--- verilog/rio_top.sv
// Relay I/O signalling: contact inputs, output relays, self-test, LEDs
// and rear serial port settings.
// Assumes contact pins are asynchronous, protection and UART logic share clock.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps

module rio_top #(
  parameter int DEBOUNCE_CYC = rio_pkg::DEBOUNCE_CYCLES,  // Debounce length
  parameter int BLINK_CYC    = rio_pkg::BLINK_CYCLES       // LED half period
) (
  input  wire logic                             clock,          // 50 MHz clock
  input  wire logic                             rst_b,          // Async reset, low
  input  wire logic [rio_pkg::LOCAL_INPUTS-1:0] local_in,       // Contact pins, 1 = shorted
  input  wire logic                             reset_button,   // Front reset pin
  input  wire logic [5:0]                       prot_inst,      // Instantaneous elements
  input  wire logic [5:0]                       prot_delayed,   // Time-delayed trips
  input  wire logic                             prot_timing,    // A timer is running
  input  wire logic                             breaker_fail,   // Breaker failure seen
  input  wire logic                             adc_ok,         // Converter check good
  input  wire logic                             dsp_ok,         // Processor check good
  input  wire logic [7:0]                       rx_addr,        // Received frame address
  input  wire logic                             rx_addr_valid,  // Address strobe
  input  wire logic [4:0]                       addr,           // Register index
  input  wire logic [15:0]                      wdata,          // Write data
  input  wire logic                             wr,             // Write strobe
  input  wire logic                             rd,             // Read strobe
  output logic      [15:0]                      rdata,          // Read data, next cycle
  output logic                                  blocking_active,    // Blocking input
  output logic                                  remote_trip_active, // Remote trip input
  output logic                                  breaker_closed,     // Breaker position
  output logic      [rio_pkg::ALL_OUTPUTS-1:0]  relay_drive,    // 1 = coil energized
  output rio_pkg::rio_leds_t                    leds,           // Front LEDs, 1 = lit
  output logic                                  osc_trigger,    // Recording start pulse
  output logic                                  event_log,      // Fault event pulse
  output logic                                  frame_for_us,   // Address match pulse
  output logic      [1:0]                       serial_parity,  // Active parity
  output logic                                  serial_baud,    // 0 = 9600, 1 = 19200
  output logic      [7:0]                       node_address,   // Node address
  output logic                                  test_done       // Power-up test over
);

  // ****************************************
  // Constants and helpers
  // ****************************************
  localparam logic [17:0] DEB_LIM   = 18'(DEBOUNCE_CYC);
  localparam logic [23:0] BLINK_LIM = 24'(BLINK_CYC);

  // Reset image of the whole state
  function automatic rio_pkg::rio_state_t reset_value();
    rio_pkg::rio_state_t s;
    s         = '0;
    s.st      = rio_pkg::ST_INIT;
    s.node    = rio_pkg::NODE_RESET;
    s.sum_ref = rio_pkg::SUM_RESET;
    return s;
  endfunction

  localparam rio_pkg::rio_state_t STATE_RESET = reset_value();

  // Index names a stored setting
  function automatic logic is_param(input logic [4:0] a);
    return (a == rio_pkg::REG_CTRL) || (a == rio_pkg::REG_SERIAL) ||
           (a == rio_pkg::REG_NODE) || (a == rio_pkg::REG_SUM) ||
           ((a >= rio_pkg::REG_OUTCFG0) && (a <= rio_pkg::REG_OUTCFG6));
  endfunction

  // Setting word by checksum position
  function automatic logic [15:0] param_word(input rio_pkg::rio_state_t s,
                                             input logic [3:0] i);
    logic [15:0] w;
    w = 16'h0000;
    case (i)
      4'h0: w = {14'h0000, s.ctrl};
      4'h1: w = {13'h0000, s.serial};
      4'h2: w = {8'h00, s.node};
      default: w = {10'h000, s.outcfg[3'(i - 4'h3)]};
    endcase
    return w;
  endfunction

  // Register read decode, unmapped reads zero
  function automatic logic [15:0] read_word(input rio_pkg::rio_state_t s,
                                            input logic [4:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      rio_pkg::REG_CTRL:      w = {14'h0000, s.ctrl};
      rio_pkg::REG_SERIAL:    w = {13'h0000, s.serial};
      rio_pkg::REG_NODE:      w = {8'h00, s.node};
      rio_pkg::REG_STATUS:    w = {7'h00, s.act_baud, s.act_parity, s.test_done,
                                   s.trip_latch, s.irf_fault, s.deb};
      rio_pkg::REG_EXP_IN:    w = {6'h00, s.exp_in};
      rio_pkg::REG_OUT_STATE: w = {9'h000, s.relay};
      rio_pkg::REG_SUM:       w = s.sum_ref;
      default: begin
        if ((a >= rio_pkg::REG_OUTCFG0) && (a <= rio_pkg::REG_OUTCFG6)) begin
          w = {10'h000, s.outcfg[3'(a - rio_pkg::REG_OUTCFG0)]};
        end
      end
    endcase
    return w;
  endfunction

  rio_pkg::rio_state_t cur;
  rio_pkg::rio_state_t next_cur;
  logic [15:0]         elem;
  logic                press;
  logic                irf_el;
  logic                any_trip;
  logic                detect;
  logic                fault_clr;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_cur  = cur;
    detect    = 1'b0;
    fault_clr = 1'b0;
    // Pins through two flops first
    next_cur.sync1  = local_in;
    next_cur.sync2  = cur.sync1;
    next_cur.btn_s1 = reset_button;
    next_cur.btn_s2 = cur.btn_s1;
    next_cur.btn_prev = cur.btn_s2;
    press = cur.btn_s2 & ~cur.btn_prev;
    // Debounce: level must hold for the full count
    for (int i = 0; i < rio_pkg::LOCAL_INPUTS; i++) begin
      if (cur.sync2[i] == cur.deb[i]) begin
        next_cur.dcnt[i] = 18'h00000;
      end else if (cur.dcnt[i] >= DEB_LIM - 18'h00001) begin
        next_cur.deb[i]  = cur.sync2[i];
        next_cur.dcnt[i] = 18'h00000;
      end else begin
        next_cur.dcnt[i] = cur.dcnt[i] + 18'h00001;
      end
    end
    next_cur.deb_prev = cur.deb[2];
    // Flash phase shared by the red and power LEDs
    if (cur.blink_cnt >= BLINK_LIM - 24'h000001) begin
      next_cur.blink_cnt = 24'h000000;
      next_cur.blink     = ~cur.blink;
    end else begin
      next_cur.blink_cnt = cur.blink_cnt + 24'h000001;
    end

    // Self-test sequencer, loops forever after the first pass
    case (cur.st)
      rio_pkg::ST_INIT: begin
        next_cur.idx = 4'h0;
        next_cur.acc = 16'h0000;
        next_cur.st  = rio_pkg::ST_SUM;
      end
      rio_pkg::ST_SUM: begin
        next_cur.acc = cur.acc + param_word(cur, cur.idx);
        if (cur.idx == 4'(rio_pkg::PARAM_WORDS - 1)) begin
          next_cur.st = rio_pkg::ST_CHECK;
        end else begin
          next_cur.idx = cur.idx + 4'h1;
        end
      end
      rio_pkg::ST_CHECK: begin
        detect = (cur.acc != cur.sum_ref) | ~adc_ok | ~dsp_ok;
        next_cur.test_done = 1'b1;
        if (!cur.test_done) begin
          next_cur.act_parity = cur.serial[2:1];
          next_cur.act_baud   = cur.serial[0];
        end
        next_cur.idx = 4'h0;
        next_cur.acc = 16'h0000;
        next_cur.st  = rio_pkg::ST_SUM;
      end
      default: begin
        next_cur.st = rio_pkg::ST_INIT;
      end
    endcase

    // Register writes
    if (wr) begin
      case (addr)
        rio_pkg::REG_CTRL: next_cur.ctrl = wdata[1:0];
        rio_pkg::REG_SERIAL: begin
          if (wdata[2:1] != rio_pkg::PAR_BAD) begin
            next_cur.serial = wdata[2:0];
          end
        end
        rio_pkg::REG_NODE: begin
          if ((wdata[15:8] == 8'h00) && (wdata[7:0] >= rio_pkg::NODE_MIN) &&
              (wdata[7:0] <= rio_pkg::NODE_MAX)) begin
            next_cur.node = wdata[7:0];
          end
        end
        rio_pkg::REG_STATUS: fault_clr = wdata[rio_pkg::STAT_FAULT];
        rio_pkg::REG_EXP_IN: next_cur.exp_in = wdata[9:0];
        rio_pkg::REG_SUM: next_cur.sum_ref = wdata;
        default: begin
          if ((addr >= rio_pkg::REG_OUTCFG0) && (addr <= rio_pkg::REG_OUTCFG6)) begin
            next_cur.outcfg[3'(addr - rio_pkg::REG_OUTCFG0)] = wdata[5:0];
          end
        end
      endcase
      // A stored setting restarts the checksum pass
      if (is_param(addr)) begin
        next_cur.st  = rio_pkg::ST_SUM;
        next_cur.idx = 4'h0;
        next_cur.acc = 16'h0000;
      end
    end

    // Internal fault: set wins over software clear
    next_cur.irf_fault = detect | (cur.irf_fault & ~fault_clr);
    next_cur.event_log = detect & ~cur.irf_fault & cur.ctrl[rio_pkg::CTRL_IRF_TRIP];
    irf_el = cur.irf_fault & cur.ctrl[rio_pkg::CTRL_IRF_TRIP];

    // Element vector for relay assignment
    elem = {1'b0, breaker_fail, irf_el, cur.deb[1], prot_delayed, prot_inst};
    any_trip = (|prot_delayed) | cur.deb[1] | irf_el;
    next_cur.trip_latch = any_trip | (cur.trip_latch & ~press);

    // Relay drive: selected element, then polarity
    for (int i = 0; i < rio_pkg::ALL_OUTPUTS; i++) begin
      next_cur.relay[i] = (cur.outcfg[i].enable & elem[cur.outcfg[i].source]) ^
                          cur.outcfg[i].normally_energized;
    end

    // Front LEDs
    next_cur.leds.green_open = ~cur.deb[2];
    next_cur.leds.red_closed = breaker_fail ? cur.blink : cur.deb[2];
    next_cur.leds.red_trip   = cur.trip_latch | (prot_timing & cur.blink);
    next_cur.leds.power_fault = cur.irf_fault ? cur.blink : 1'b1;

    // Recording trigger on breaker opening
    next_cur.osc_trig = cur.ctrl[rio_pkg::CTRL_EXT_TRIG] & cur.deb_prev & ~cur.deb[2];

    // Frame address filter
    next_cur.frame_hit = rx_addr_valid & (rx_addr == cur.node);

    // Read data valid the cycle after the strobe only
    next_cur.rdata = rd ? read_word(cur, addr) : 16'h0000;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state flops
  assign rdata              = cur.rdata;
  assign blocking_active    = cur.deb[0];
  assign remote_trip_active = cur.deb[1];
  assign breaker_closed     = cur.deb[2];
  assign relay_drive        = cur.relay;
  assign leds               = cur.leds;
  assign osc_trigger        = cur.osc_trig;
  assign event_log          = cur.event_log;
  assign frame_for_us       = cur.frame_hit;
  assign serial_parity      = cur.act_parity;
  assign serial_baud        = cur.act_baud;
  assign node_address       = cur.node;
  assign test_done          = cur.test_done;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_param_wr;
    wr && is_param(addr);
  endsequence

  sequence s_trip_fault;
    detect && !cur.irf_fault && cur.ctrl[rio_pkg::CTRL_IRF_TRIP];
  endsequence

  // No further setting write that would restart the pass
  sequence s_quiet;
    !(wr && is_param(addr));
  endsequence

  a_node_range: assert property (
    node_address >= rio_pkg::NODE_MIN && node_address <= rio_pkg::NODE_MAX)
    else $error("node address out of range");

  a_green_open: assert property (
    $fell(cur.deb[2]) |=> leds.green_open)
    else $error("green LED not lit on breaker open");

  a_ext_trigger: assert property (
    $fell(cur.deb[2]) && cur.ctrl[rio_pkg::CTRL_EXT_TRIG] |=> osc_trigger)
    else $error("no recording trigger on breaker opening");

  a_trip_hold: assert property (
    cur.trip_latch && !press |=> cur.trip_latch ##1 leds.red_trip)
    else $error("trip latch dropped without reset button");

  a_relay_polarity: assert property (
    cur.outcfg[3].enable && elem[cur.outcfg[3].source] |=>
      relay_drive[3] != $past(cur.outcfg[3].normally_energized))
    else $error("normally energized relay did not drop on trip");

  a_no_trip_mode: assert property (
    !cur.ctrl[rio_pkg::CTRL_IRF_TRIP] |-> !elem[rio_pkg::ELEM_IRF] && !next_cur.event_log)
    else $error("fault acted on outputs in no-trip mode");

  a_fault_event: assert property (
    s_trip_fault |=> event_log && cur.irf_fault)
    else $error("trip-mode fault not logged");

  a_checksum_restart: assert property (
    s_param_wr |=> cur.st == rio_pkg::ST_SUM && cur.idx == 4'h0)
    else $error("checksum pass not restarted on setting write");

  a_addr_match: assert property (
    frame_for_us |-> $past(rx_addr) == $past(node_address) && $past(rx_addr_valid))
    else $error("answer to a foreign address");

  a_framing_hold: assert property (
    test_done |=> $stable(serial_parity) && $stable(serial_baud))
    else $error("framing changed after power-up");

  a_checksum_finish: assert property (
    s_param_wr ##1 s_quiet[*5] ##1 s_quiet[*5] |=> cur.st == rio_pkg::ST_CHECK)
    else $error("checksum pass did not reach the check step");

  a_fault_latch: assert property (
    detect |=> cur.irf_fault)
    else $error("detected fault not latched");

  a_event_single: assert property (
    event_log |=> !event_log)
    else $error("fault event longer than one cycle");

  a_power_steady: assert property (
    !cur.irf_fault |=> leds.power_fault)
    else $error("power LED not steady without fault");

  a_trip_dark: assert property (
    !cur.trip_latch && !prot_timing |=> !leds.red_trip)
    else $error("trip LED lit with no trip or timing");

  a_frame_quiet: assert property (
    !$past(rx_addr_valid) |-> !frame_for_us)
    else $error("address match without a strobe");

endmodule

//--- verilog/rio_pkg.sv
// Shared constants and types for the relay I/O signalling block.
// Assumes a single 50 MHz clock domain and a plain register port.
package rio_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int LOCAL_INPUTS  = 3;
  localparam int EXP_INPUTS    = 10;
  localparam int LOCAL_OUTPUTS = 3;
  localparam int EXP_OUTPUTS   = 4;
  localparam int ALL_OUTPUTS   = LOCAL_OUTPUTS + EXP_OUTPUTS;
  localparam int PARAM_WORDS   = 10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 50_000_000;
  localparam int DEBOUNCE_US     = 5000;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int BLINK_HALF_MS   = 250;
  localparam int BLINK_CYCLES    = CLK_HZ / 1000 * BLINK_HALF_MS;

  // ****************************************
  // Register indexes and fields
  // ****************************************
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_SERIAL    = 5'h01;
  localparam logic [4:0] REG_NODE      = 5'h02;
  localparam logic [4:0] REG_STATUS    = 5'h03;
  localparam logic [4:0] REG_EXP_IN    = 5'h04;
  localparam logic [4:0] REG_OUT_STATE = 5'h05;
  localparam logic [4:0] REG_SUM       = 5'h06;
  localparam logic [4:0] REG_OUTCFG0   = 5'h08;
  localparam logic [4:0] REG_OUTCFG6   = 5'h0E;
  localparam int CTRL_EXT_TRIG = 0;
  localparam int CTRL_IRF_TRIP = 1;
  localparam int STAT_FAULT    = 3;
  localparam logic [7:0]  NODE_MIN   = 8'h01;
  localparam logic [7:0]  NODE_MAX   = 8'hFA;
  localparam logic [7:0]  NODE_RESET = 8'h01;
  localparam logic [15:0] SUM_RESET  = 16'h0001;
  localparam logic [1:0]  PAR_NONE   = 2'h0;
  localparam logic [1:0]  PAR_ODD    = 2'h1;
  localparam logic [1:0]  PAR_EVEN   = 2'h2;
  localparam logic [1:0]  PAR_BAD    = 2'h3;

  // ****************************************
  // Element vector positions
  // ****************************************
  localparam int ELEM_DELAYED0 = 6;
  localparam int ELEM_REMOTE   = 12;
  localparam int ELEM_IRF      = 13;
  localparam int ELEM_BF       = 14;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_INIT  = 3'h1,
    ST_SUM   = 3'h2,
    ST_CHECK = 3'h4
  } rio_test_t;

  typedef struct packed {
    logic       enable;
    logic       normally_energized;
    logic [3:0] source;
  } rio_outcfg_t;

  typedef struct packed {
    logic green_open;
    logic red_closed;
    logic red_trip;
    logic power_fault;
  } rio_leds_t;

  typedef struct packed {
    rio_test_t                     st;
    logic [2:0]                    sync1;
    logic [2:0]                    sync2;
    logic [2:0]                    deb;
    logic [2:0][17:0]              dcnt;
    logic                          deb_prev;
    logic                          btn_s1;
    logic                          btn_s2;
    logic                          btn_prev;
    logic [23:0]                   blink_cnt;
    logic                          blink;
    logic [1:0]                    ctrl;
    logic [2:0]                    serial;
    logic [7:0]                    node;
    logic [15:0]                   sum_ref;
    logic [9:0]                    exp_in;
    rio_outcfg_t [ALL_OUTPUTS-1:0] outcfg;
    logic [3:0]                    idx;
    logic [15:0]                   acc;
    logic                          test_done;
    logic                          irf_fault;
    logic                          trip_latch;
    logic [1:0]                    act_parity;
    logic                          act_baud;
    logic [ALL_OUTPUTS-1:0]        relay;
    rio_leds_t                     leds;
    logic                          osc_trig;
    logic                          event_log;
    logic                          frame_hit;
    logic [15:0]                   rdata;
  } rio_state_t;

endpackage

//--- tb/rio_field.sv
// Far side model: dry field contacts and the supervisory bus master.
// Assumes the bench sets its requests just after a rising clock edge.
`timescale 1ns/10ps
module rio_field (
  input  wire logic       clock,     // Bench clock
  input  wire logic [2:0] shorted,   // Contacts closed
  input  wire logic [7:0] target,    // Slave to call
  input  wire logic       call,      // Call request
  output logic      [2:0] pins,      // Contact pins
  output logic      [7:0] rx_addr,   // Called address
  output logic            rx_valid   // Address strobe
);
  // Closed contact shorts the terminals and reads 1
  assign pins = shorted;
  // One address per call; an idle bus shows inverted junk
  initial begin
    rx_addr  = 8'h00;
    rx_valid = 1'b0;
  end
  always @(posedge clock) begin
    rx_valid <= call;
    rx_addr  <= call ? target : ~rx_addr;
  end
endmodule

//--- tb/tb.sv
// Bench for the relay I/O block: contacts, relays, LEDs, self-test, serial.
// Assumes rio_field as far side; debounce and blink counts are shortened.
`timescale 1ns/10ps
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0, rst_b = 1'b0, button = 1'b0, timing = 1'b0, bfail = 1'b0;
  logic adc_ok = 1'b1, dsp_ok = 1'b1, wr = 1'b0, rd = 1'b0, call = 1'b0;
  logic [5:0]         inst = 6'h00, dly = 6'h00;
  logic [2:0]         shorted = 3'h0, pins;
  logic [7:0]         target = 8'h00, rx_addr, node;
  logic [4:0]         addr = 5'h00;
  logic [15:0]        wdata = 16'h0000, rdata, probe;
  logic               rx_valid, blk, rmt, closed, osc, evt, hit, baud, st_ok;
  logic [6:0]         relay;
  logic [1:0]         parity;
  rio_pkg::rio_leds_t leds;
  logic [15:0]        sh [0:14];
  int                 n_fail = 0, checks_done = 0, n_osc = 0, n_evt = 0, n_hit = 0;

  // Watched levels, one bit each
  assign probe = {1'b0, leds.power_fault, leds.red_trip, leds.red_closed, leds.green_open,
                  st_ok, rmt, blk, closed, relay};

  rio_field field (.clock(clock), .shorted(shorted), .target(target), .call(call),
                   .pins(pins), .rx_addr(rx_addr), .rx_valid(rx_valid));
  rio_top #(.DEBOUNCE_CYC(4), .BLINK_CYC(8)) uut (
    .clock(clock), .rst_b(rst_b), .local_in(pins), .reset_button(button),
    .prot_inst(inst), .prot_delayed(dly), .prot_timing(timing), .breaker_fail(bfail),
    .adc_ok(adc_ok), .dsp_ok(dsp_ok), .rx_addr(rx_addr), .rx_addr_valid(rx_valid),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .blocking_active(blk), .remote_trip_active(rmt), .breaker_closed(closed),
    .relay_drive(relay), .leds(leds), .osc_trigger(osc), .event_log(evt),
    .frame_for_us(hit), .serial_parity(parity), .serial_baud(baud),
    .node_address(node), .test_done(st_ok));

  // 50 MHz clock
  always #10 clock = ~clock;
  // Pulse counters
  always @(posedge clock) begin
    if (osc === 1'b1) n_osc++;
    if (evt === 1'b1) n_evt++;
    if (hit === 1'b1) n_hit++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Checksum of the stored settings as software keeps it
  function automatic logic [15:0] csum();
    logic [15:0] s;
    s = sh[0] + sh[1] + sh[2];
    for (int i = 8; i < 15; i++) s += sh[i];
    return s;
  endfunction
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  // Setting write followed back to back by the matching sum
  task automatic wr_cfg(input logic [4:0] a, input logic [15:0] d);
    sh[a] = d;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr_reg(rio_pkg::REG_SUM, csum());
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    v = rdata;
  endtask
  task automatic wait_probe(input string what, input int i, input logic v);
    int k;
    for (k = 0; k < 40 && probe[i] !== v; k++) @(posedge clock);
    check(what, {15'h0, probe[i]}, {15'h0, v});
    if (k == 40) test_done();
  endtask
  task automatic flash_chk(input string what, input int i, input logic fl);
    int n;
    logic p;
    n = 0;
    p = probe[i];
    repeat (24) begin
      @(posedge clock);
      if (probe[i] !== p) n++;
      p = probe[i];
    end
    check(what, {15'h0, n > 0}, {15'h0, fl});
  endtask
  task automatic call_node(input logic [7:0] t, input logic [15:0] hits);
    int h;
    h = n_hit;
    target <= t;
    call <= 1'b1;
    @(posedge clock);
    call <= 1'b0;
    repeat (4) @(posedge clock);
    check("frame hit", 16'(n_hit - h), hits);
  endtask
  task automatic press();
    button <= 1'b1;
    repeat (4) @(posedge clock);
    button <= 1'b0;
    @(posedge clock);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_power_node();
    logic [15:0] v;
    wait_probe("self test", 10, 1'b1);
    flash_chk("power steady", 14, 1'b0);
    wait_probe("power lit", 14, 1'b1);
    wait_probe("green lit", 11, 1'b1);
    call_node(8'h01, 16'h0001);
    wr_cfg(rio_pkg::REG_NODE, 16'h00FA);
    wr_reg(rio_pkg::REG_NODE, 16'h0000);
    wr_reg(rio_pkg::REG_NODE, 16'h00FB);
    rd_reg(rio_pkg::REG_NODE, v);
    check("node reg", v, 16'h00FA);
    check("node pins", {8'h00, node}, 16'h00FA);
    call_node(8'h01, 16'h0000);
    call_node(8'hFA, 16'h0001);
    $display("end power and node");
  endtask
  task automatic t_inputs();
    logic [15:0] v;
    int o;
    shorted <= 3'h4;
    repeat (2) @(posedge clock);
    shorted <= 3'h0;
    repeat (12) @(posedge clock);
    wait_probe("glitch", 7, 1'b0);
    shorted <= 3'h7;
    wait_probe("closed", 7, 1'b1);
    wait_probe("blocking", 8, 1'b1);
    wait_probe("remote", 9, 1'b1);
    wait_probe("green off", 11, 1'b0);
    flash_chk("red steady", 12, 1'b0);
    wait_probe("red lit", 12, 1'b1);
    rd_reg(rio_pkg::REG_STATUS, v);
    check("status in", {13'h0, v[2:0]}, 16'h0007);
    wr_cfg(rio_pkg::REG_CTRL, 16'h0001);
    o = n_osc;
    shorted <= 3'h0;
    wait_probe("opened", 7, 1'b0);
    repeat (3) @(posedge clock);
    check("osc start", 16'(n_osc - o), 16'h0001);
    wait_probe("green back", 11, 1'b1);
    shorted <= 3'h4;
    wait_probe("reclosed", 7, 1'b1);
    bfail <= 1'b1;
    flash_chk("red flash", 12, 1'b1);
    bfail <= 1'b0;
    $display("end inputs");
  endtask
  task automatic t_relays();
    press();
    wait_probe("trip clear", 13, 1'b0);
    wr_cfg(rio_pkg::REG_OUTCFG0, 16'h0026);
    wr_cfg(rio_pkg::REG_OUTCFG0 + 5'h03, 16'h003C);
    wait_probe("out rest", 0, 1'b0);
    wait_probe("exp rest", 3, 1'b1);
    dly <= 6'h01;
    wait_probe("out trip", 0, 1'b1);
    wait_probe("trip led", 13, 1'b1);
    dly <= 6'h00;
    wait_probe("out back", 0, 1'b0);
    flash_chk("trip steady", 13, 1'b0);
    wait_probe("trip held", 13, 1'b1);
    shorted <= 3'h6;
    wait_probe("exp drop", 3, 1'b0);
    shorted <= 3'h4;
    wait_probe("exp back", 3, 1'b1);
    press();
    wait_probe("trip reset", 13, 1'b0);
    timing <= 1'b1;
    flash_chk("trip timing", 13, 1'b1);
    timing <= 1'b0;
    $display("end relays");
  endtask
  task automatic t_fault_serial();
    logic [15:0] v;
    int e;
    wr_cfg(rio_pkg::REG_CTRL, 16'h0003);
    wr_cfg(rio_pkg::REG_OUTCFG0 + 5'h01, 16'h002D);
    e = n_evt;
    adc_ok <= 1'b0;
    wait_probe("fault out", 1, 1'b1);
    flash_chk("fault led", 14, 1'b1);
    check("fault event", 16'(n_evt - e), 16'h0001);
    adc_ok <= 1'b1;
    wr_cfg(rio_pkg::REG_CTRL, 16'h0001);
    wr_reg(rio_pkg::REG_STATUS, 16'h0008);
    dsp_ok <= 1'b0;
    repeat (30) @(posedge clock);
    wait_probe("no trip out", 1, 1'b0);
    flash_chk("no trip led", 14, 1'b1);
    check("no event", 16'(n_evt - e), 16'h0001);
    dsp_ok <= 1'b1;
    wr_reg(rio_pkg::REG_SUM, 16'hBEEF);
    wr_reg(rio_pkg::REG_STATUS, 16'h0008);
    repeat (30) @(posedge clock);
    rd_reg(rio_pkg::REG_STATUS, v);
    check("sum fault", {15'h0, v[3]}, 16'h0001);
    wr_cfg(rio_pkg::REG_SERIAL, 16'h0003);
    wr_reg(rio_pkg::REG_SERIAL, 16'h0006);
    rd_reg(rio_pkg::REG_SERIAL, v);
    check("serial reg", v, 16'h0003);
    check("parity held", {14'h0, parity}, {14'h0, rio_pkg::PAR_NONE});
    check("baud held", {15'h0, baud}, 16'h0000);
    wr_reg(rio_pkg::REG_EXP_IN, 16'h0201);
    rd_reg(rio_pkg::REG_EXP_IN, v);
    check("exp inputs", v, 16'h0201);
    rd_reg(5'h1F, v);
    check("unmapped", v, 16'h0000);
    $display("end fault and serial");
  endtask

  task automatic t_power_cycle();
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    check("node reset again", {8'h00, node}, 16'h0001);
    for (int i = 0; i < 15; i++) sh[i] = 16'h0000;
    sh[2] = 16'h0001;
    rst_b <= 1'b1;
    wr_cfg(rio_pkg::REG_SERIAL, 16'h0003);
    wait_probe("retest", 10, 1'b1);
    check("parity new", {14'h0, parity}, {14'h0, rio_pkg::PAR_ODD});
    check("baud new", {15'h0, baud}, 16'h0001);
    wr_cfg(rio_pkg::REG_SERIAL, 16'h0004);
    repeat (30) @(posedge clock);
    check("parity kept", {14'h0, parity}, {14'h0, rio_pkg::PAR_ODD});
    $display("end power cycle");
  endtask

  // Main sequence
  initial begin
    for (int i = 0; i < 15; i++) sh[i] = 16'h0000;
    sh[2] = 16'h0001;
    repeat (4) @(posedge clock);
    check("node in reset", {8'h00, node}, 16'h0001);
    rst_b <= 1'b1;
    t_power_node();
    t_inputs();
    t_relays();
    t_fault_serial();
    t_power_cycle();
    test_done();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    test_done();
  end
endmodule
